//--- hw/gp_pkg.sv
// Overview of operation
// - Per-pin operations touch only selected pins
// - Each pin: input, output or hardware-owned
// - Trigger: falling, rising, both, low, high
// - Stored trigger reads back in same encoding
// - Drive: 2, 4, 8, 8 mA slewed
// - Seven pad types including analog
// - Pad settings stored even on inputs
// - Drive and pad type read back
// - Clear removes latched interrupt of selected pins whose data bit is set
// - Mask blocks a selected pin's interrupt
// - Enable passes a selected pin's interrupt
// - Reset: input, lowest drive, push-pull, GPIO
// - Data write/read act on selected pins
// - Raw and masked status both readable
`default_nettype none
package gp_pkg;
	localparam int GP_PINS = 8;
	localparam int GP_ADDR_W = 8;

	// Register byte offsets
	localparam logic [GP_ADDR_W-1:0] GP_OFF_SELECT = 8'h00;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_DATA = 8'h04;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_DIR_CMD = 8'h08;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_TRIG_CMD = 8'h0c;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_PAD_CMD = 8'h10;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_INDEX = 8'h14;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_PIN_CFG = 8'h18;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_INT_EN = 8'h1c;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_INT_DIS = 8'h20;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_INT_CLR = 8'h24;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_INT_RAW = 8'h28;
	localparam logic [GP_ADDR_W-1:0] GP_OFF_INT_MASKED = 8'h2c;

	// Field positions
	localparam int GP_DIR_LSB = 0;
	localparam int GP_TRIG_LSB = 4;
	localparam int GP_DRIVE_LSB = 8;
	localparam int GP_PAD_LSB = 12;
	localparam int GP_CMD_DRIVE_LSB = 0;
	localparam int GP_CMD_PAD_LSB = 4;

	localparam logic [1:0] GP_RESP_OKAY = 2'h0;
	localparam logic [1:0] GP_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		gp_dir_input = 2'h0,
		gp_dir_output = 2'h1,
		gp_dir_hw_controlled = 2'h2
	} gp_dir_t;

	typedef enum logic [2:0] {
		gp_trig_falling = 3'h0,
		gp_trig_rising = 3'h1,
		gp_trig_both = 3'h2,
		gp_trig_low = 3'h3,
		gp_trig_high = 3'h4
	} gp_trig_t;

	typedef enum logic [1:0] {
		gp_drive_lowest = 2'h0,
		gp_drive_medium = 2'h1,
		gp_drive_highest = 2'h2,
		gp_drive_highest_slewed = 2'h3
	} gp_drive_t;

	typedef enum logic [2:0] {
		gp_pad_push_pull = 3'h0,
		gp_pad_push_pull_pullup = 3'h1,
		gp_pad_push_pull_pulldown = 3'h2,
		gp_pad_open_drain = 3'h3,
		gp_pad_open_drain_pullup = 3'h4,
		gp_pad_open_drain_pulldown = 3'h5,
		gp_pad_analog = 3'h6
	} gp_pad_type_t;

	typedef enum logic {
		gp_bus_idle = 1'b0,
		gp_bus_busy = 1'b1
	} gp_bus_state_t;

	typedef struct packed {
		gp_pad_type_t pad_type;
		gp_drive_t drive;
	} gp_pad_t;

	typedef struct packed {
		gp_dir_t dir;
		gp_trig_t trig;
		gp_pad_t pad;
	} gp_pin_cfg_t;

	// Reset state of every pin
	localparam gp_pin_cfg_t GP_CFG_RESET = '{
		dir: gp_dir_input,
		trig: gp_trig_falling,
		pad: '{pad_type: gp_pad_push_pull, drive: gp_drive_lowest}
	};
	localparam logic [7:0] GP_SEL_RESET = 8'h00;
	localparam logic [2:0] GP_INDEX_RESET = 3'h0;
	localparam logic [7:0] GP_OUT_RESET = 8'h00;
	localparam logic [7:0] GP_INT_EN_RESET = 8'h00;

	function automatic logic [5:0] gp_word(input logic [GP_ADDR_W-1:0] a);
		return a[GP_ADDR_W-1:2];
	endfunction : gp_word

	function automatic logic gp_is_open_drain(input gp_pad_type_t p);
		return (p == gp_pad_open_drain) || (p == gp_pad_open_drain_pullup) ||
			(p == gp_pad_open_drain_pulldown);
	endfunction : gp_is_open_drain
endpackage : gp_pkg
`default_nettype wire

//--- hw/gp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gp_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage is read only by the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : gp_sync
`default_nettype wire

//--- hw/gp_detect.sv
`timescale 1ns/100ps
`default_nettype none
module gp_detect import gp_pkg::*; #(
	parameter int N = GP_PINS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Synchronised levels and per-pin trigger
	input wire logic [N-1:0] lvl,
	input wire gp_trig_t [N-1:0] trig,
	// Clear strobe per pin
	input wire logic [N-1:0] clr,
	// Raw status per pin
	output logic [N-1:0] raw
);
	logic [N-1:0] prev;
	logic [N-1:0] next_prev;
	logic [N-1:0] latch;
	logic [N-1:0] next_latch;

	always_comb begin
		logic ev;
		ev = 1'b0;
		next_prev = lvl;
		next_latch = latch;
		raw = '0;
		for (int i = 0; i < N; i++) begin
			ev = 1'b0;
			// prev follows lvl in every mode, so a trigger change alone never looks like an edge
			case (trig[i])
				gp_trig_falling: ev = prev[i] & ~lvl[i];
				gp_trig_rising: ev = ~prev[i] & lvl[i];
				gp_trig_both: ev = prev[i] ^ lvl[i];
				default: ev = 1'b0;
			endcase
			if (trig[i] == gp_trig_low || trig[i] == gp_trig_high) begin
				// Level status is not latched; it drops when the level goes away
				next_latch[i] = 1'b0;
				raw[i] = (trig[i] == gp_trig_high) ? lvl[i] : ~lvl[i];
			end else begin
				// New edge beats a clear in the same cycle
				next_latch[i] = (latch[i] & ~clr[i]) | ev;
				raw[i] = latch[i];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev <= '0;
			latch <= '0;
		end else begin
			prev <= next_prev;
			latch <= next_latch;
		end
	end
endmodule : gp_detect
`default_nettype wire

//--- hw/gp_port.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module gp_port import gp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [GP_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [GP_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Pad side
	input wire logic [GP_PINS-1:0] pin_in,
	output logic [GP_PINS-1:0] pin_out,
	output logic [GP_PINS-1:0] pin_oe,
	output gp_pad_t [GP_PINS-1:0] pad_cfg,
	// Peripheral side
	input wire logic [GP_PINS-1:0] periph_out,
	input wire logic [GP_PINS-1:0] periph_oe,
	output logic [GP_PINS-1:0] periph_in,
	// Interrupt
	output logic irq
);
	// Write channel state
	gp_bus_state_t wr_state;
	gp_bus_state_t next_wr_state;
	logic aw_full;
	logic next_aw_full;
	logic [GP_ADDR_W-1:0] aw_addr_q;
	logic [GP_ADDR_W-1:0] next_aw_addr;
	logic w_full;
	logic next_w_full;
	logic [31:0] w_data_q;
	logic [31:0] next_w_data;
	logic [3:0] w_strb_q;
	logic [3:0] next_w_strb;
	logic [1:0] bresp_q;
	logic [1:0] next_bresp;
	logic do_wr;
	logic wr_en;
	logic [5:0] wr_word;

	// Read channel state
	gp_bus_state_t rd_state;
	gp_bus_state_t next_rd_state;
	logic [31:0] rdata_q;
	logic [31:0] next_rdata;
	logic [1:0] rresp_q;
	logic [1:0] next_rresp;

	// Configuration
	logic [GP_PINS-1:0] pin_select_mask;
	logic [GP_PINS-1:0] next_pin_select_mask;
	logic [2:0] pin_index;
	logic [2:0] next_pin_index;
	gp_pin_cfg_t [GP_PINS-1:0] cfg;
	gp_pin_cfg_t [GP_PINS-1:0] next_cfg;
	logic [GP_PINS-1:0] out_val;
	logic [GP_PINS-1:0] next_out_val;
	logic [GP_PINS-1:0] int_en;
	logic [GP_PINS-1:0] next_int_en;

	// Pins and interrupts
	logic [GP_PINS-1:0] pin_sync;
	logic [GP_PINS-1:0] raw_stat;
	logic [GP_PINS-1:0] masked_stat;
	logic [GP_PINS-1:0] clr_pulse;
	gp_trig_t [GP_PINS-1:0] trig_vec;
	logic [GP_PINS-1:0] next_pin_out;
	logic [GP_PINS-1:0] next_pin_oe;
	logic next_irq;

	gp_sync #(
		.W(GP_PINS)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d(pin_in),
		.q(pin_sync)
	);

	always_comb begin
		for (int i = 0; i < GP_PINS; i++) begin
			trig_vec[i] = cfg[i].trig;
		end
	end

	gp_detect #(
		.N(GP_PINS)
	) u_detect (
		.clk(clk),
		.arst_n(arst_n),
		.lvl(pin_sync),
		.trig(trig_vec),
		.clr(clr_pulse),
		.raw(raw_stat)
	);

	// Write channel: address and data may arrive in either order
	assign awready = (wr_state == gp_bus_idle) && !aw_full;
	assign wready = (wr_state == gp_bus_idle) && !w_full;
	assign bvalid = (wr_state == gp_bus_busy);
	assign bresp = bresp_q;
	assign do_wr = (wr_state == gp_bus_idle) && aw_full && w_full;
	assign wr_word = gp_word(aw_addr_q);
	// Every writable field lives in byte lane 0
	assign wr_en = do_wr && w_strb_q[0];

	always_comb begin
		next_wr_state = wr_state;
		next_aw_full = aw_full;
		next_aw_addr = aw_addr_q;
		next_w_full = w_full;
		next_w_data = w_data_q;
		next_w_strb = w_strb_q;
		next_bresp = bresp_q;
		if (awvalid && awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_full = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (do_wr) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_wr_state = gp_bus_busy;
			next_bresp = (wr_word > gp_word(GP_OFF_INT_MASKED)) ? GP_RESP_SLVERR : GP_RESP_OKAY;
		end
		if (wr_state == gp_bus_busy && bready) begin
			next_wr_state = gp_bus_idle;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_state <= gp_bus_idle;
			aw_full <= 1'b0;
			aw_addr_q <= '0;
			w_full <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bresp_q <= GP_RESP_OKAY;
		end else begin
			wr_state <= next_wr_state;
			aw_full <= next_aw_full;
			aw_addr_q <= next_aw_addr;
			w_full <= next_w_full;
			w_data_q <= next_w_data;
			w_strb_q <= next_w_strb;
			bresp_q <= next_bresp;
		end
	end

	// Read channel: one outstanding read, data registered
	assign arready = (rd_state == gp_bus_idle);
	assign rvalid = (rd_state == gp_bus_busy);
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign masked_stat = raw_stat & int_en;

	always_comb begin
		next_rd_state = rd_state;
		next_rdata = rdata_q;
		next_rresp = rresp_q;
		if (arvalid && arready) begin
			next_rd_state = gp_bus_busy;
			next_rdata = '0;
			next_rresp = GP_RESP_OKAY;
			case (gp_word(araddr))
				gp_word(GP_OFF_SELECT): next_rdata[7:0] = pin_select_mask;
				gp_word(GP_OFF_DATA): next_rdata[7:0] = pin_sync & pin_select_mask;
				gp_word(GP_OFF_INDEX): next_rdata[2:0] = pin_index;
				gp_word(GP_OFF_PIN_CFG): begin
					next_rdata[GP_DIR_LSB +: 2] = cfg[pin_index].dir;
					next_rdata[GP_TRIG_LSB +: 3] = cfg[pin_index].trig;
					next_rdata[GP_DRIVE_LSB +: 2] = cfg[pin_index].pad.drive;
					next_rdata[GP_PAD_LSB +: 3] = cfg[pin_index].pad.pad_type;
				end
				gp_word(GP_OFF_INT_EN): next_rdata[7:0] = int_en;
				gp_word(GP_OFF_INT_RAW): next_rdata[7:0] = raw_stat;
				gp_word(GP_OFF_INT_MASKED): next_rdata[7:0] = masked_stat;
				gp_word(GP_OFF_DIR_CMD), gp_word(GP_OFF_TRIG_CMD), gp_word(GP_OFF_PAD_CMD),
				gp_word(GP_OFF_INT_DIS), gp_word(GP_OFF_INT_CLR): next_rdata = '0;
				default: next_rresp = GP_RESP_SLVERR;
			endcase
		end
		if (rd_state == gp_bus_busy && rready) begin
			next_rd_state = gp_bus_idle;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_state <= gp_bus_idle;
			rdata_q <= '0;
			rresp_q <= GP_RESP_OKAY;
		end else begin
			rd_state <= next_rd_state;
			rdata_q <= next_rdata;
			rresp_q <= next_rresp;
		end
	end

	// Configuration writes; encodings outside the enumerations are ignored
	always_comb begin
		next_pin_select_mask = pin_select_mask;
		next_pin_index = pin_index;
		next_cfg = cfg;
		next_out_val = out_val;
		next_int_en = int_en;
		clr_pulse = '0;
		if (wr_en) begin
			case (wr_word)
				gp_word(GP_OFF_SELECT): next_pin_select_mask = w_data_q[7:0];
				gp_word(GP_OFF_INDEX): next_pin_index = w_data_q[2:0];
				gp_word(GP_OFF_DATA): begin
					// All selected pins change together
					next_out_val = (out_val & ~pin_select_mask) |
						(w_data_q[7:0] & pin_select_mask);
				end
				gp_word(GP_OFF_DIR_CMD): begin
					for (int i = 0; i < GP_PINS; i++) begin
						if (pin_select_mask[i] && w_data_q[1:0] != 2'h3) begin
							next_cfg[i].dir = gp_dir_t'(w_data_q[1:0]);
						end
					end
				end
				gp_word(GP_OFF_TRIG_CMD): begin
					for (int i = 0; i < GP_PINS; i++) begin
						if (pin_select_mask[i] && w_data_q[2:0] <= 3'h4) begin
							next_cfg[i].trig = gp_trig_t'(w_data_q[2:0]);
						end
					end
				end
				gp_word(GP_OFF_PAD_CMD): begin
					// Stored whatever the direction; inputs only feel the pull
					for (int i = 0; i < GP_PINS; i++) begin
						if (pin_select_mask[i] && w_data_q[GP_CMD_PAD_LSB +: 3] != 3'h7) begin
							next_cfg[i].pad.drive = gp_drive_t'(w_data_q[GP_CMD_DRIVE_LSB +: 2]);
							next_cfg[i].pad.pad_type = gp_pad_type_t'(w_data_q[GP_CMD_PAD_LSB +: 3]);
						end
					end
				end
				gp_word(GP_OFF_INT_EN): next_int_en = int_en | pin_select_mask;
				gp_word(GP_OFF_INT_DIS): next_int_en = int_en & ~pin_select_mask;
				// Clear lands together with the response, since it is issued as the write is taken
				gp_word(GP_OFF_INT_CLR): clr_pulse = w_data_q[7:0] & pin_select_mask;
				default: next_int_en = int_en;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_select_mask <= GP_SEL_RESET;
			pin_index <= GP_INDEX_RESET;
			cfg <= {GP_PINS{GP_CFG_RESET}};
			out_val <= GP_OUT_RESET;
			int_en <= GP_INT_EN_RESET;
		end else begin
			pin_select_mask <= next_pin_select_mask;
			pin_index <= next_pin_index;
			cfg <= next_cfg;
			out_val <= next_out_val;
			int_en <= next_int_en;
		end
	end

	// Pad drive; open drain only ever pulls low
	always_comb begin
		logic val;
		logic en;
		val = 1'b0;
		en = 1'b0;
		next_pin_out = '0;
		next_pin_oe = '0;
		for (int i = 0; i < GP_PINS; i++) begin
			case (cfg[i].dir)
				gp_dir_output: begin
					val = out_val[i];
					en = 1'b1;
				end
				gp_dir_hw_controlled: begin
					val = periph_out[i];
					en = periph_oe[i];
				end
				default: begin
					val = 1'b0;
					en = 1'b0;
				end
			endcase
			if (cfg[i].pad.pad_type == gp_pad_analog) begin
				next_pin_out[i] = 1'b0;
				next_pin_oe[i] = 1'b0;
			end else if (gp_is_open_drain(cfg[i].pad.pad_type)) begin
				next_pin_out[i] = 1'b0;
				next_pin_oe[i] = en & ~val;
			end else begin
				next_pin_out[i] = val;
				next_pin_oe[i] = en;
			end
		end
		next_irq = |masked_stat;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out <= '0;
			pin_oe <= '0;
			irq <= 1'b0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			irq <= next_irq;
		end
	end

	always_comb begin
		for (int i = 0; i < GP_PINS; i++) begin
			pad_cfg[i] = cfg[i].pad;
		end
	end

	// Peripherals see the synchronised pin
	assign periph_in = pin_sync;
endmodule : gp_port
`default_nettype wire

//--- testbench/gp_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module gp_pad_model import gp_pkg::*; (
	// Clock
	input wire logic clk,
	// Device pad side
	input wire logic [GP_PINS-1:0] pin_out,
	input wire logic [GP_PINS-1:0] pin_oe,
	input wire gp_pad_t [GP_PINS-1:0] pad_cfg,
	// Board drivers
	input wire logic [GP_PINS-1:0] ext_val,
	input wire logic [GP_PINS-1:0] ext_en,
	// Resolved level
	output logic [GP_PINS-1:0] pin_in
);
	logic [GP_PINS-1:0] last = '0;
	always_comb begin
		for (int i = 0; i < GP_PINS; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pad_cfg[i].pad_type inside {gp_pad_push_pull_pullup, gp_pad_open_drain_pullup}) begin
				pin_in[i] = 1'b1;
			end else if (pad_cfg[i].pad_type inside {gp_pad_push_pull_pulldown, gp_pad_open_drain_pulldown}) begin
				pin_in[i] = 1'b0;
			end else begin
				pin_in[i] = ~last[i];
			end
		end
	end
	// Floating pins toggle so a stale level never passes for a driven one
	always_ff @(posedge clk) begin
		last <= pin_in;
	end
endmodule : gp_pad_model
`default_nettype wire

//--- testbench/gp_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module gp_port_chk import gp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Pads
	input wire logic [GP_PINS-1:0] pin_in,
	input wire logic [GP_PINS-1:0] pin_oe,
	input wire gp_pad_t [GP_PINS-1:0] pad_cfg,
	input wire logic [GP_PINS-1:0] periph_in
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [1:0] up;
	logic [1:0] next_up;
	logic [GP_PINS-1:0] analog_oe;
	always_comb begin
		next_up = (up == 2'h3) ? up : up + 2'h1;
		for (int i = 0; i < GP_PINS; i++) begin
			analog_oe[i] = pin_oe[i] && (pad_cfg[i].pad_type == gp_pad_analog);
		end
	end
	// Sync history is only meaningful once three edges have passed since reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			up <= 2'h0;
		end else begin
			up <= next_up;
		end
	end
	sequence s_write_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_read_taken;
		arvalid && arready;
	endsequence
	a_write_answer: assert property (s_write_taken |=> !bvalid ##1 bvalid) else $error("write response late");
	a_read_answer: assert property (s_read_taken |=> rvalid) else $error("read data late");
	a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
	a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
	a_read_refused: assert property (rvalid |-> !arready) else $error("read taken while busy");
	a_write_refused: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
	a_err_data_zero: assert property (rvalid && rresp == GP_RESP_SLVERR |-> rdata == 32'h0) else $error("error read data");
	a_pin_sync: assert property (up == 2'h3 |-> periph_in == $past(pin_in, 2)) else $error("sync delay");
	a_analog_quiet: assert property (analog_oe == '0) else $error("analog pad driven");
endmodule : gp_port_chk
bind gp_port gp_port_chk chk_i (.clk(clk), .arst_n(arst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pin_in(pin_in), .pin_oe(pin_oe), .pad_cfg(pad_cfg),
	.periph_in(periph_in));
`default_nettype wire

//--- testbench/gp_port_pin_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module gp_port_pin_control_test import gp_pkg::*;;
	logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, ext_val, ext_en, periph_out, periph_oe, seed, v;
	logic [31:0] wdata;
	wire logic awready, wready, bvalid, arready, rvalid, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] pin_in, pin_out, pin_oe, periph_in;
	wire gp_pad_t [GP_PINS-1:0] pad_cfg;
	int n_mismatch, tests_run;
	logic [63:0] exp_r[$];
	logic [63:0] exp_b[$];

	gp_port uut (.clk(clk), .arst_n(arst_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pad_cfg(pad_cfg), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .irq(irq));
	gp_pad_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad_cfg(pad_cfg), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic hang(input string nm);
		n_mismatch++;
		$display("unexpected %s expected answer seen none", nm);
		give_verdict();
	endtask : hang

	// Looks mid-cycle so the registered interrupt has settled, then realigns to the edge
	task automatic chk_irq(input logic e);
		@(negedge clk);
		chk("irq", 64'(e), 64'(irq));
		@(posedge clk);
	endtask : chk_irq

	task automatic do_reset;
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		exp_b.push_back(64'(e));
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 40);
		if (n >= 40) hang("bvalid");
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		exp_r.push_back(64'({e, d}));
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 40);
		if (n >= 40) hang("rvalid");
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	// Answers are compared in arrival order against what the driver noted
	always @(posedge clk) begin
		if (bvalid && bready && exp_b.size() > 0) chk("bresp", exp_b.pop_front(), 64'(bresp));
		if (rvalid && rready && exp_r.size() > 0) chk("rdata", exp_r.pop_front(), 64'({rresp, rdata}));
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, ext_val, ext_en, v} = '0;
		wdata = '0;
		arst_n = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		seed = 8'h24;
		periph_out = lfsr(seed);
		periph_oe = lfsr(periph_out);
		do_reset();
		chk("pad_cfg", 64'h0, 64'(pad_cfg));
		rd(GP_OFF_PIN_CFG, 32'h0, GP_RESP_OKAY);
		for (int k = 0; k < 8; k++) begin
			wr(GP_OFF_SELECT, 32'(8'h01 << k), GP_RESP_OKAY);
			wr(GP_OFF_DIR_CMD, 32'(k % 3), GP_RESP_OKAY);
			wr(GP_OFF_TRIG_CMD, 32'(k % 5), GP_RESP_OKAY);
			wr(GP_OFF_PAD_CMD, 32'(((k % 7) << 4) | (k % 4)), GP_RESP_OKAY);
		end
		for (int k = 0; k < 8; k++) begin
			wr(GP_OFF_INDEX, 32'(k), GP_RESP_OKAY);
			rd(GP_OFF_PIN_CFG, 32'(((k % 7) << 12) | ((k % 4) << 8) | ((k % 5) << 4) | (k % 3)), GP_RESP_OKAY);
			chk("pad_cfg", 64'(((k % 7) << 2) | (k % 4)), 64'(pad_cfg[k]));
		end
		$display("test config done");
		wr(GP_OFF_SELECT, 32'h82, GP_RESP_OKAY);
		wr(GP_OFF_DATA, 32'hff, GP_RESP_OKAY);
		repeat (3) @(posedge clk);
		rd(GP_OFF_DATA, 32'h82, GP_RESP_OKAY);
		chk("pin_oe", 64'(8'h92 | (periph_oe & 8'h04) | (periph_oe & ~periph_out & 8'h20)), 64'(pin_oe));
		chk("pin_out", 64'(8'h82 | (periph_out & 8'h04)), 64'(pin_out));
		rd(8'h30, 32'h0, GP_RESP_SLVERR);
		wr(8'h30, 32'hff, GP_RESP_SLVERR);
		$display("test data done");
		ext_en <= 8'hff;
		do_reset();
		wr(GP_OFF_SELECT, 32'hff, GP_RESP_OKAY);
		wr(GP_OFF_TRIG_CMD, 32'(gp_trig_rising), GP_RESP_OKAY);
		seed = lfsr(seed);
		v = seed | 8'h81;
		ext_val <= v;
		repeat (4) @(posedge clk);
		rd(GP_OFF_INT_RAW, 32'(v), GP_RESP_OKAY);
		rd(GP_OFF_INT_MASKED, 32'h0, GP_RESP_OKAY);
		chk_irq(1'b0);
		wr(GP_OFF_SELECT, 32'h0f, GP_RESP_OKAY);
		wr(GP_OFF_INT_EN, 32'h0, GP_RESP_OKAY);
		rd(GP_OFF_INT_MASKED, 32'(v & 8'h0f), GP_RESP_OKAY);
		chk_irq(1'b1);
		wr(GP_OFF_SELECT, 32'h01, GP_RESP_OKAY);
		wr(GP_OFF_INT_DIS, 32'h0, GP_RESP_OKAY);
		rd(GP_OFF_INT_MASKED, 32'(v & 8'h0e), GP_RESP_OKAY);
		chk_irq((v & 8'h0e) != 8'h0);
		wr(GP_OFF_SELECT, 32'h03, GP_RESP_OKAY);
		wr(GP_OFF_INT_CLR, 32'h03, GP_RESP_OKAY);
		rd(GP_OFF_INT_RAW, 32'(v & 8'hfc), GP_RESP_OKAY);
		wr(GP_OFF_SELECT, 32'h80, GP_RESP_OKAY);
		wr(GP_OFF_TRIG_CMD, 32'(gp_trig_high), GP_RESP_OKAY);
		ext_val <= v & 8'h7f;
		repeat (4) @(posedge clk);
		rd(GP_OFF_INT_RAW, 32'(v & 8'h7c), GP_RESP_OKAY);
		$display("test interrupt done");
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		hang("run");
	end
endmodule : gp_port_pin_control_test
`default_nettype wire
